// File: rtl/rbi_pkg.sv
/*
 reading buffer and interrupt logic: shared constants, offsets, modes.
 assumes a single 100 MHz clock and a plain one-cycle register port.
*/
package rbi_pkg;
	// buffer geometry
	localparam int unsigned DEPTH_LOG2   = 14;
	localparam int unsigned DEPTH        = 16384;
	localparam int unsigned DATA_W       = 16;
	localparam int unsigned CHAN_W       = 16;
	// near-full block threshold in free readings
	localparam logic [14:0] NEAR_FREE    = 15'h1000;
	// register offsets (word index)
	localparam logic [3:0] A_CTRL        = 4'h0;
	localparam logic [3:0] A_PER_TRIG    = 4'h1;
	localparam logic [3:0] A_CMD         = 4'h2;
	localparam logic [3:0] A_STATUS      = 4'h3;
	localparam logic [3:0] A_FETCH       = 4'h4;
	localparam logic [3:0] A_COUNT       = 4'h5;
	localparam logic [3:0] A_LASTINTR    = 4'h6;
	localparam logic [3:0] A_SERVICE     = 4'h7;
	// command register bit positions
	localparam int unsigned CMD_ARM      = 0;
	localparam int unsigned CMD_DISARM   = 1;
	localparam int unsigned CMD_SCAN     = 2;
	localparam int unsigned CMD_CONFSCAN = 3;
	localparam int unsigned CMD_DISCARD  = 4;
	localparam int unsigned CMD_MULTI    = 5;
	// control register fields
	localparam int unsigned CTRL_MODE_LO = 0;
	localparam int unsigned CTRL_DEST    = 2;
	// reset values
	localparam logic [15:0] PER_TRIG_RST = 16'h0001;
	localparam logic [15:0] LASTINTR_RST = 16'hffff;
	typedef enum logic [1:0] {
		M_ANY      = 2'b00,
		M_NEARFULL = 2'b01,
		M_END      = 2'b10,
		M_COMPLETE = 2'b11
	} rbi_mode_t;
	typedef enum logic {
		D_HOST = 1'b0,
		D_PORT = 1'b1
	} rbi_dest_t;
endpackage

// File: rtl/rbi_mem.sv
/*
 reading memory: one write port, one registered read port.
 assumes addresses are in range; read data valid one cycle after raddr.
*/
module rbi_mem
	import rbi_pkg::*;
(
	// clock
	input  wire logic                  mclk,
	// write side
	input  wire logic                  we,
	input  wire logic [DEPTH_LOG2-1:0] waddr,
	input  wire logic [DATA_W-1:0]     wdata,
	// read side
	input  wire logic [DEPTH_LOG2-1:0] raddr,
	output logic      [DATA_W-1:0]     rdata
);
	logic [DATA_W-1:0] mem [DEPTH];

	// memory has no reset: contents are only meaningful via pointers
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// File: rtl/rbi_core.sv
/*
 reading buffer and interrupt logic of a high-speed voltmeter.
 assumes results arrive as one-cycle strobes synchronous to mclk and that
 the host writes the storage mode before it arms the interrupt.
*/
// Design decisions made here: the register addresses and the strobed register port.
// Operation
// - readings and interrupts go to one destination
// - destination resets to host frame
// - port destination: refuse fetches, interrupt port only
// - results buffered until read or discarded
// - reads allowed only while data available
// - storage mode picks four behaviours
// - any-reading: available if nonempty, full aborts
// - any-reading: interrupt while nonempty, clear if empty
// - near-full: available at 4096 free or end
// - near-full: no overwrite, full aborts scan
// - near-full: interrupt at 4096 free or count
// - near-full: disarm clears if running or freed
// - end mode: available if nonempty, full aborts
// - end mode: interrupt at count, disarm clears
// - complete: available at end, overwrite, no abort
// - complete: interrupt at count, disarm clears
// - complete mode keeps only most recent readings
// - disarmed at reset and scan commands
// - last serviced channel, minus one after reset
// - readings per trigger range 1 to 65535
module rbi_core
	import rbi_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              rst,
	// register port
	input  wire logic [3:0]        addr,
	input  wire logic [15:0]       wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [15:0]       rdata,
	// measurement side
	input  wire logic              trig,
	input  wire logic              result_vld,
	input  wire logic [DATA_W-1:0] result,
	output logic                   scanning,
	// interrupt outputs
	output logic                   host_irq,
	output logic                   port_irq,
	// parallel port reading stream
	output logic                   port_vld,
	output logic      [DATA_W-1:0] port_data,
	input  wire logic              port_rdy
);
	////////////////////////////////////////////////////////////////
	// state
	rbi_mode_t             mode_q;
	rbi_dest_t             dest_q;
	logic [15:0]           per_trig_q;
	logic                  armed_q;
	logic                  irq_q;
	logic                  run_q;
	logic                  ended_q;
	logic [15:0]           taken_q;
	logic [DEPTH_LOG2-1:0] wp_q;
	logic [DEPTH_LOG2-1:0] rp_q;
	logic [DEPTH_LOG2:0]   cnt_q;
	logic [15:0]           last_q;
	logic [1:0]            stale_q;
	logic [15:0]           reg_q;
	logic                  pv_q;
	logic [DATA_W-1:0]     mem_q;

	////////////////////////////////////////////////////////////////
	// decode
	wire wr_ctrl  = wr && addr == A_CTRL;
	wire wr_ptrig = wr && addr == A_PER_TRIG;
	wire wr_cmd   = wr && addr == A_CMD;
	wire wr_serv  = wr && addr == A_SERVICE;
	wire c_arm    = wr_cmd && wdata[CMD_ARM];
	wire c_disarm = wr_cmd && wdata[CMD_DISARM];
	wire c_scan   = wr_cmd && (wdata[CMD_SCAN] || wdata[CMD_CONFSCAN]);
	// control and per-trigger writes and the scan and discard commands empty the buffer
	wire c_clear  = wr_ctrl || wr_ptrig || c_scan ||
		(wr_cmd && wdata[CMD_DISCARD]);
	wire to_host  = dest_q == D_HOST;

	////////////////////////////////////////////////////////////////
	// occupancy and availability
	wire        empty    = cnt_q == '0;
	wire        full     = cnt_q[DEPTH_LOG2];
	wire [14:0] free     = 15'(DEPTH) - cnt_q;
	wire        nearfull = free <= NEAR_FREE;
	// end of the count as a one-cycle event: once a disarm has cleared
	// it, a later re-arm must not revive a stale end-of-scan request
	wire        count_done = run_q && result_vld && !c_clear &&
		!(full && mode_q != M_COMPLETE) &&
		taken_q == per_trig_q - 16'h0001;
	// data-available condition per mode
	logic data_avail;
	always_comb begin
		unique case (mode_q)
			M_ANY:      data_avail = !empty;
			M_NEARFULL: data_avail = !empty &&
				(nearfull || ended_q);
			M_END:      data_avail = !empty;
			M_COMPLETE: data_avail = !empty && ended_q;
		endcase
	end
	// interrupt request condition per mode
	logic irq_set;
	always_comb begin
		unique case (mode_q)
			M_ANY:      irq_set = !empty;
			M_NEARFULL: irq_set = nearfull || count_done;
			M_END:      irq_set = count_done;
			M_COMPLETE: irq_set = count_done;
		endcase
	end
	// whether disarming may drop a pending request
	logic irq_clr_ok;
	always_comb begin
		unique case (mode_q)
			M_ANY:      irq_clr_ok = empty;
			M_NEARFULL: irq_clr_ok = run_q || free > NEAR_FREE;
			default:    irq_clr_ok = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// writes and reads of the buffer
	wire overwrite = mode_q == M_COMPLETE;
	// complete mode wraps, keeping only the latest DEPTH readings
	wire push    = run_q && result_vld && (!full || overwrite);
	wire abort   = run_q && result_vld && full && !overwrite;
	wire fetch_ok = to_host && data_avail;
	wire host_pop = rd && addr == A_FETCH && fetch_ok;
	wire port_pop = pv_q && port_rdy;
	wire pop     = (host_pop || port_pop) && !(push && full);
	wire drop    = push && full;                        // oldest is lost
	wire last_rd = run_q && result_vld && taken_q == per_trig_q - 16'h0001;

	rbi_mem u_mem (
		.mclk  (mclk),
		.we    (push),
		.waddr (wp_q),
		.wdata (result),
		.raddr (rp_q),
		.rdata (mem_q)
	);

	// pointers and occupancy
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else if (c_clear) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) wp_q <= wp_q + 1'b1;
			if (pop || drop) rp_q <= rp_q + 1'b1;
			if (push && !full && !pop) cnt_q <= cnt_q + 1'b1;
			else if (pop && !push) cnt_q <= cnt_q - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// scan sequence: trigger starts, count or abort ends it
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			run_q   <= 1'b0;
			ended_q <= 1'b0;
			taken_q <= '0;
		end else if (c_clear) begin
			run_q   <= 1'b0;
			ended_q <= 1'b0;
			taken_q <= '0;
		end else if (!run_q && trig && !ended_q) begin
			run_q   <= 1'b1;
			taken_q <= '0;
		end else if (abort) begin
			run_q   <= 1'b0;
			ended_q <= 1'b1;
		end else if (run_q && result_vld) begin
			taken_q <= taken_q + 16'h0001;
			if (last_rd) begin
				run_q   <= 1'b0;
				ended_q <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// arm state and the interrupt level
	// a set in the same cycle as a disarm is dropped, so a permitted clear wins
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			armed_q <= 1'b0;
			irq_q   <= 1'b0;
		end else begin
			if (c_scan || c_disarm) armed_q <= 1'b0;
			else if (c_arm) armed_q <= 1'b1;
			if (c_scan) irq_q <= 1'b0;
			else if (armed_q && irq_set && !c_disarm) irq_q <= 1'b1;
			else if (c_disarm && irq_clr_ok) irq_q <= 1'b0;
		end
	end
	// request shown only while armed, routed to one destination
	assign host_irq = irq_q && armed_q && to_host;
	assign port_irq = irq_q && armed_q && !to_host;

	////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_q  <= M_ANY;
			dest_q  <= D_HOST;
			per_trig_q <= PER_TRIG_RST;
			last_q  <= LASTINTR_RST;
		end else begin
			if (wr_ctrl) begin
				mode_q <= rbi_mode_t'(wdata[CTRL_MODE_LO +: 2]);
				dest_q <= rbi_dest_t'(wdata[CTRL_DEST]);
			end
			// zero is outside the range and is held at one
			if (wr_ptrig) begin
				per_trig_q <= (wdata == 16'h0000) ? PER_TRIG_RST : wdata;
			end
			if (wr_serv) last_q <= wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// parallel port stream: one reading in flight; the memory output
	// lags the read pointer by two edges after a move or a write to the
	// head, so loading waits that long to avoid a stale or repeated word
	wire fill_head = push && wp_q == rp_q;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pv_q      <= 1'b0;
			port_data <= '0;
			stale_q   <= '0;
		end else begin
			stale_q <= {stale_q[0],
				port_pop || c_clear || drop || fill_head};
			if (c_clear || port_pop) begin
				pv_q <= 1'b0;
			end else if (!pv_q && !to_host && data_avail &&
				stale_q == 2'b00) begin
				pv_q      <= 1'b1;
				port_data <= mem_q;
			end
		end
	end
	assign port_vld = pv_q;
	assign scanning = run_q;

	////////////////////////////////////////////////////////////////
	// read mux; fetch data comes straight from the memory port
	always_comb begin
		unique case (addr)
			A_CTRL:     reg_q = {13'h0000, dest_q, mode_q};
			A_PER_TRIG: reg_q = per_trig_q;
			A_STATUS:   reg_q = {8'h00, to_host, full, ended_q, run_q,
				irq_q, armed_q, data_avail, !fetch_ok};
			A_COUNT:    reg_q = 16'(cnt_q);
			A_LASTINTR: reg_q = last_q;
			default:    reg_q = 16'h0000;
		endcase
	end
	logic [15:0] hold_q;
	logic        fetch_q;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hold_q  <= '0;
			fetch_q <= 1'b0;
		end else begin
			hold_q  <= rd ? reg_q : 16'h0000;
			fetch_q <= host_pop;
		end
	end
	// refused fetch reads as zero; status bit 0 tells why
	assign rdata = fetch_q ? mem_q : hold_q;
endmodule

// File: sim/rbi_checker.sv
/*
 checker for rbi_core: interrupt gating, destination, register reads.
 assumes one strobe at a time on the register port and a single clock.
*/
module rbi_checker
	import rbi_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// register port
	input wire logic [3:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [15:0] rdata,
	// measurement and interrupt side
	input wire logic        result_vld,
	input wire logic        scanning,
	input wire logic        host_irq,
	input wire logic        port_irq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	logic        dest_q;
	logic        armed_q;
	logic        serv_q;
	logic [1:0]  mode_q;
	logic [15:0] chan_q;
	wire cmd_w = wr && addr == A_CMD;
	wire arm_w = cmd_w && wdata[CMD_ARM];
	wire off_w = cmd_w && (wdata[CMD_DISARM] || wdata[CMD_SCAN]
		|| wdata[CMD_CONFSCAN]);
	// shadow of settings; disarm wins over arm in one word
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			{dest_q, armed_q, serv_q, mode_q, chan_q} <= '0;
		end else begin
			if (wr && addr == A_CTRL) begin
				{dest_q, mode_q} <= wdata[2:0];
			end
			if (wr && addr == A_SERVICE) begin
				serv_q <= 1'b1;
				chan_q <= wdata;
			end
			armed_q <= off_w ? 1'b0 : (arm_w ? 1'b1 : armed_q);
		end
	end
	sequence s_off; off_w ##1 !arm_w; endsequence
	property p_off; s_off |-> ##1 (!host_irq && !port_irq); endproperty
	a_off: assert property (p_off) else $error("irq after disarm");
	property p_dest; dest_q && $past(dest_q) |-> !host_irq; endproperty
	a_dest: assert property (p_dest) else $error("host irq to port");
	property p_host; !dest_q && $past(!dest_q) |-> !port_irq; endproperty
	a_host: assert property (p_host) else $error("port irq to host");
	property p_rel; $fell(rst) |-> !host_irq && !port_irq && !scanning;
	endproperty
	a_rel: assert property (p_rel) else $error("busy after reset");
	property p_fetch; rd && addr == A_FETCH && dest_q |=> rdata == 16'h0000;
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch not refused");
	property p_last; rd && addr == A_LASTINTR
		|=> rdata == (serv_q ? chan_q : LASTINTR_RST); endproperty
	a_last: assert property (p_last) else $error("last channel wrong");
	property p_stat; rd && addr == A_STATUS
		|=> rdata[7] == !dest_q && rdata[2] == armed_q; endproperty
	a_stat: assert property (p_stat) else $error("status wrong");
	property p_endirq; mode_q[1] && $rose(host_irq) |-> !scanning; endproperty
	a_endirq: assert property (p_endirq) else $error("early irq");
	property p_any; mode_q == M_ANY && armed_q && !dest_q && scanning
		&& result_vld && !off_w |-> ##[1:3] host_irq; endproperty
	a_any: assert property (p_any) else $error("no irq on data");
endmodule
bind rbi_core rbi_checker chk (.mclk(mclk), .rst(rst), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.result_vld(result_vld), .scanning(scanning),
	.host_irq(host_irq), .port_irq(port_irq));

// File: sim/rbi_host.sv
/*
 host frame model: drives the register port and services interrupts.
 assumes the device answers reads in the cycle after the strobe.
*/
module rbi_host
	import rbi_pkg::*;
(
	// clock
	input  wire logic        mclk,
	// register port
	output logic      [3:0]  addr,
	output logic      [15:0] wdata,
	output logic             wr,
	output logic             rd,
	input  wire logic [15:0] rdata,
	// interrupt request
	input  wire logic        host_irq
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		{addr, wdata, wr, rd} = '0;
	end
	// released lines show the inverse so stale values are not trusted
	task automatic put(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask
	task automatic get(input logic [3:0] a, output logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		addr <= ~a;
		#1 d = rdata;
	endtask
	// wait for the request, log the channel, then disarm it ourselves
	task automatic service(input logic [15:0] chan, output bit ok);
		ok = 1'b0;
		for (int i = 0; i < 200 && !ok; i++) begin
			@(posedge mclk);
			ok = (host_irq === 1'b1);
		end
		if (ok) begin
			put(A_SERVICE, chan);
			put(A_CMD, 16'h0002);
		end
	endtask
endmodule

// File: sim/rbi_core_tb.sv
/*
 testbench for rbi_core: scenarios for the any, end and complete modes and the port destination.
 assumes rbi_host drives the register port; bench drives the rest.
*/
`define CHK(n, e, v) begin \
	checks_done++; \
	if ((v) !== (e)) begin \
		fails++; \
		$display("Error %s expected %h seen %h", n, e, v); \
	end \
end
module rbi_core_tb;
	import rbi_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 0, rst = 1, wr, rd, trig = 0, result_vld = 0, port_rdy = 0;
	logic [3:0]  addr;
	logic [15:0] wdata, rdata, port_data, result = '0;
	logic        scanning, host_irq, port_irq, port_vld;
	int          fails = 0, checks_done = 0;
	always #5 mclk = ~mclk;
	rbi_core dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .trig(trig),
		.result_vld(result_vld), .result(result), .scanning(scanning),
		.host_irq(host_irq), .port_irq(port_irq), .port_vld(port_vld),
		.port_data(port_data), .port_rdy(port_rdy));
	rbi_host host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .host_irq(host_irq));
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic feed(input logic [15:0] v);
		@(posedge mclk);
		result_vld <= 1'b1;
		result <= v;
		@(posedge mclk);
		result_vld <= 1'b0;
	endtask
	// mode and count first, so the buffer is emptied before the trigger
	task automatic start(input logic [15:0] ctrl, input logic [15:0] n);
		host.put(A_CTRL, ctrl);
		host.put(A_PER_TRIG, n);
		@(posedge mclk);
		trig <= 1'b1;
		@(posedge mclk);
		trig <= 1'b0;
	endtask
	task automatic fetch(input string n, input logic [15:0] e);
		logic [15:0] d;
		host.get(A_FETCH, d);
		`CHK(n, e, d)
	endtask
	initial begin
		logic [15:0] d;
		bit ok;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		host.get(A_LASTINTR, d);
		`CHK("last", LASTINTR_RST, d)
		host.get(A_STATUS, d);
		`CHK("dest", 1'b1, d[7])
		host.put(A_PER_TRIG, 16'h0000);
		host.get(A_PER_TRIG, d);
		`CHK("per trigger", PER_TRIG_RST, d)
		$display("test reset done");
		start(16'h0000, 16'h0003);
		host.put(A_CMD, 16'h0001);
		for (int i = 0; i < 3; i++) feed(16'h00a0 + 16'(i));
		host.service(16'h0005, ok);
		`CHK("any irq", 1'b1, ok)
		host.get(A_STATUS, d);
		`CHK("kept", 1'b1, d[3])
		host.get(A_LASTINTR, d);
		`CHK("served", 16'h0005, d)
		for (int i = 0; i < 3; i++) fetch("oldest", 16'h00a0 + 16'(i));
		fetch("empty", 16'h0000);
		host.put(A_CMD, 16'h0002);
		host.get(A_STATUS, d);
		`CHK("dropped", 1'b0, d[3])
		$display("test any done");
		start(16'h0002, 16'h0002);
		host.put(A_CMD, 16'h0001);
		feed(16'h00b0);
		host.get(A_STATUS, d);
		`CHK("early", 1'b0, host_irq)
		feed(16'h00b1);
		host.service(16'h0006, ok);
		`CHK("end irq", 1'b1, ok)
		host.put(A_CMD, 16'h0001);
		host.get(A_STATUS, d);
		`CHK("cleared", 1'b0, host_irq)
		fetch("end data", 16'h00b0);
		$display("test end done");
		start(16'h0003, 16'h0002);
		feed(16'h00c0);
		fetch("not yet", 16'h0000);
		feed(16'h00c1);
		host.get(A_STATUS, d);
		`CHK("complete irq", 1'b1, host_irq)
		fetch("complete", 16'h00c0);
		host.put(A_CMD, 16'h0002);
		host.get(A_STATUS, d);
		`CHK("complete clr", 1'b0, d[3])
		$display("test complete done");
		start(16'h0004, 16'h0001);
		host.put(A_CMD, 16'h0001);
		feed(16'h00d0);
		fetch("refused", 16'h0000);
		repeat (4) @(posedge mclk);
		`CHK("port irq", 1'b1, port_irq)
		`CHK("port vld", 1'b1, port_vld)
		`CHK("port data", 16'h00d0, port_data)
		port_rdy <= 1'b1;
		repeat (2) @(posedge mclk);
		port_rdy <= 1'b0;
		`CHK("port taken", 1'b0, port_vld)
		$display("test port done");
		give_verdict();
	end
endmodule
